// *** rtl/ssp_pkg.sv ***
// constants shared by the synchronous serial port pin block
package ssp_pkg;
  // ----------------------------------------------------------------
  // clocking and sizes
  // ----------------------------------------------------------------
  localparam int unsigned PCLK_HZ     = 40_000_000; // system clock rate
  localparam int unsigned NPIN        = 6;          // serial port pins
  localparam int unsigned WORD_BITS   = 8;          // serial word length
  localparam int unsigned FIFO_DEPTH  = 8;          // transmit buffer words
  localparam int unsigned EXT_MIN_PH  = 6;          // least external clock period in system cycles

  // ----------------------------------------------------------------
  // pin indices within the pin vectors
  // ----------------------------------------------------------------
  localparam int unsigned PIN_SC0 = 0; // serial_ctrl_line_zero / gpio_pin_zero
  localparam int unsigned PIN_SC1 = 1; // serial_ctrl_line_one / gpio_pin_one
  localparam int unsigned PIN_SC2 = 2; // serial_ctrl_line_two / gpio_pin_two
  localparam int unsigned PIN_SCK = 3; // serial_bit_clock_line / gpio_pin_three
  localparam int unsigned PIN_SRD = 4; // serial_rx_data_line / gpio_pin_four
  localparam int unsigned PIN_STD = 5; // serial_tx_data_line / gpio_pin_five

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00; // mode and clocking control
  localparam logic [7:0] OFF_PCR  = 8'h04; // port_control_register
  localparam logic [7:0] OFF_PDR  = 8'h08; // port_direction_register
  localparam logic [7:0] OFF_GPIO = 8'h0c; // gpio drive value / pin levels
  localparam logic [7:0] OFF_TXD  = 8'h10; // transmit word (write only)
  localparam logic [7:0] OFF_RXD  = 8'h14; // receive word (read pops)
  localparam logic [7:0] OFF_STAT = 8'h18; // status, write 1 clears overrun

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN       = 0;  // serial engine enable
  localparam int unsigned CTRL_SYNC     = 1;  // 1 synchronous, 0 asynchronous
  localparam int unsigned CTRL_SCK_OUT  = 2;  // bit clock driven by the port
  localparam int unsigned CTRL_FS_OUT   = 3;  // line two frame sync driven
  localparam int unsigned CTRL_RXCK_OUT = 4;  // async receive clock driven
  localparam int unsigned CTRL_RXFS_OUT = 5;  // async receive frame sync driven
  localparam int unsigned CTRL_FLAGS    = 6;  // sync: lines zero/one are flags
  localparam int unsigned CTRL_FLAG0    = 7;  // serial flag zero value
  localparam int unsigned CTRL_FLAG1    = 8;  // serial flag one value
  localparam int unsigned CTRL_DIV_LSB  = 16; // half-period divider field
  localparam int unsigned CTRL_DIV_W    = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0003_0000;

  // ----------------------------------------------------------------
  // status fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ST_TX_EMPTY = 0;
  localparam int unsigned ST_TX_FULL  = 1;
  localparam int unsigned ST_RX_FULL  = 2;
  localparam int unsigned ST_RX_OVR   = 3;
  localparam int unsigned ST_TX_BUSY  = 4;
  localparam logic [5:0]  PCR_RST     = 6'h00; // all pins gpio
  localparam logic [5:0]  PDR_RST     = 6'h00; // all gpio pins inputs
  localparam logic [5:0]  GPIO_RST    = 6'h00;
endpackage

// *** rtl/ssp_port.sv ***
// synchronous serial port: pin muxing, serial engine, apb registers
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - line zero: async rx clock, sync tx1/flag0
// - line one: async rx sync, sync tx2/flag1
// - line two: shared sync, async tx only
// - line two drives or accepts frame sync
// - bit clock serves both sync, tx async
// - rx data line input, shifted into receiver
// - tx data line driven while transmitting
// - all six pins gpio after reset
// - gpio direction from direction register bit
// - per-pin serial or gpio from control register

// ------------------------------------------------------------------
// buffer between register writes and the transmitter
// ------------------------------------------------------------------
module ssp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];      // word storage
  logic [AW-1:0]    wr_ptr_reg;       // next write slot
  logic [AW-1:0]    rd_ptr_reg;       // next read slot
  logic [AW:0]      count_reg;        // words held
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH)); // full at DEPTH words
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ------------------------------------------------------------------
// top: apb slave, serial engine and per-pin muxing
// ------------------------------------------------------------------
module ssp_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  pin_in,
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe
);
  typedef enum logic {SSP_TX_IDLE, SSP_TX_SHIFT} ssp_tx_t;
  typedef enum logic {SSP_RX_IDLE, SSP_RX_SHIFT} ssp_rx_t;

  // edge of a sampled level: dir 1 rising, 0 falling
  function automatic logic ssp_edge(input logic cur, input logic prev, input logic dir);
    ssp_edge = dir ? (cur & ~prev) : (~cur & prev);
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;        // mode, directions, divider
  logic [5:0]  pcr_reg;         // 1 = serial function on that pin
  logic [5:0]  pdr_reg;         // gpio direction, 1 = output
  logic [5:0]  gpio_reg;        // gpio drive values
  logic [5:0]  sync1_reg;       // first synchroniser stage
  logic [5:0]  sync2_reg;       // second stage, safe to use
  logic [5:0]  prev_reg;        // delayed copy for edge finding
  logic [7:0]  div_cnt_reg;     // internal clock divider
  logic        int_clk_reg;     // internally generated bit clock
  ssp_tx_t     tx_state_reg;
  logic [7:0]  tx_shift_reg;    // transmit shift register
  logic [2:0]  tx_cnt_reg;      // bits left in word
  logic        fs_drive_reg;    // internal transmit frame sync
  ssp_rx_t     rx_state_reg;
  logic [7:0]  rx_shift_reg;    // receive shift register
  logic [2:0]  rx_cnt_reg;      // bits taken in word
  logic        rxfs_drive_reg;  // internal async receive frame sync
  logic [7:0]  rx_data_reg;     // last complete word
  logic        rx_full_reg;
  logic        rx_ovr_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [5:0]  pin_out_reg;
  logic [5:0]  pin_oe_reg;

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  logic       en;
  logic       sync_mode;
  logic       sck_out;
  logic       fs_out;
  logic       rxck_out;
  logic       rxfs_out;
  logic [7:0] div;
  assign en        = ctrl_reg[ssp_pkg::CTRL_EN];
  assign sync_mode = ctrl_reg[ssp_pkg::CTRL_SYNC];
  assign sck_out   = ctrl_reg[ssp_pkg::CTRL_SCK_OUT];
  assign fs_out    = ctrl_reg[ssp_pkg::CTRL_FS_OUT];
  assign rxck_out  = ctrl_reg[ssp_pkg::CTRL_RXCK_OUT];
  assign rxfs_out  = ctrl_reg[ssp_pkg::CTRL_RXFS_OUT];
  assign div       = ctrl_reg[ssp_pkg::CTRL_DIV_LSB +: ssp_pkg::CTRL_DIV_W];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two stages before use; the third copy only serves edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      prev_reg  <= 6'h00;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ----------------------------------------------------------------
  // clock events
  // ----------------------------------------------------------------
  logic tick;
  logic int_rise;
  logic int_fall;
  logic tx_rise;
  logic rx_fall;
  logic rx_rise;
  assign tick     = (div_cnt_reg == div);
  assign int_rise = tick & ~int_clk_reg;
  assign int_fall = tick & int_clk_reg;
  // external clock halves must span three cycles to be seen here
  assign tx_rise  = sck_out ? int_rise
                  : ssp_edge(sync2_reg[ssp_pkg::PIN_SCK], prev_reg[ssp_pkg::PIN_SCK], 1'b1);
  // sync receiver shares the bit clock, async takes line zero
  assign rx_fall  = sync_mode ? (sck_out ? int_fall
                  : ssp_edge(sync2_reg[ssp_pkg::PIN_SCK], prev_reg[ssp_pkg::PIN_SCK], 1'b0))
                  : (rxck_out ? int_fall
                  : ssp_edge(sync2_reg[ssp_pkg::PIN_SC0], prev_reg[ssp_pkg::PIN_SC0], 1'b0));
  assign rx_rise  = rxck_out ? int_rise
                  : ssp_edge(sync2_reg[ssp_pkg::PIN_SC0], prev_reg[ssp_pkg::PIN_SC0], 1'b1);

  // internal bit clock, half period of div+1 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 8'h00;
      int_clk_reg <= 1'b0;
    end else if (tick) begin
      div_cnt_reg <= 8'h00;
      int_clk_reg <= ~int_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  logic       txf_in_valid;
  logic       txf_in_ready;
  logic       txf_out_valid;
  logic       txf_out_ready;
  logic [7:0] txf_out_data;
  logic       apb_done;
  logic       tx_start;

  ssp_fifo #(
    .WIDTH (ssp_pkg::WORD_BITS),
    .DEPTH (ssp_pkg::FIFO_DEPTH)
  ) u_txf (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (txf_in_valid),
    .in_ready  (txf_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (txf_out_valid),
    .out_ready (txf_out_ready),
    .out_data  (txf_out_data)
  );

  assign txf_in_valid  = apb_done & pwrite & (paddr == ssp_pkg::OFF_TXD);
  // a word starts with the internal frame sync or a seen external one
  assign tx_start      = en & tx_rise & txf_out_valid
                       & (fs_out | sync2_reg[ssp_pkg::PIN_SC2]);
  assign txf_out_ready = tx_start & ((tx_state_reg == SSP_TX_IDLE) | (tx_cnt_reg == 3'd0));

  // ----------------------------------------------------------------
  // transmitter: bit changes on rising bit clock, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= SSP_TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_cnt_reg   <= 3'd0;
      fs_drive_reg <= 1'b0;
    end else if (tx_rise) begin
      case (tx_state_reg)
        SSP_TX_IDLE: begin
          fs_drive_reg <= txf_out_ready & fs_out;
          if (txf_out_ready) begin
            tx_shift_reg <= txf_out_data;
            tx_cnt_reg   <= 3'd7;
            tx_state_reg <= SSP_TX_SHIFT;
          end
        end
        SSP_TX_SHIFT: begin
          if (tx_cnt_reg != 3'd0) begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            tx_cnt_reg   <= tx_cnt_reg - 3'd1;
            fs_drive_reg <= 1'b0;
          end else if (txf_out_ready) begin
            // back-to-back words keep the line busy
            tx_shift_reg <= txf_out_data;
            tx_cnt_reg   <= 3'd7;
            fs_drive_reg <= fs_out;
          end else begin
            tx_state_reg <= SSP_TX_IDLE;
            fs_drive_reg <= 1'b0;
          end
        end
        default: begin
          tx_state_reg <= SSP_TX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver: samples on falling bit clock after a frame sync
  // ----------------------------------------------------------------
  logic rx_fs;
  logic rx_word_done;
  assign rx_fs = sync_mode ? (fs_out ? fs_drive_reg : sync2_reg[ssp_pkg::PIN_SC2])
               : (rxfs_out ? rxfs_drive_reg : sync2_reg[ssp_pkg::PIN_SC1]);
  assign rx_word_done = rx_fall & (rx_state_reg == SSP_RX_SHIFT) & (rx_cnt_reg == 3'd7);

  // async receive frame sync raised on the rising edge just before an idle receiver's first sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxfs_drive_reg <= 1'b0;
    end else if (rx_rise) begin
      rxfs_drive_reg <= en & ~sync_mode & rxfs_out & (rx_state_reg == SSP_RX_IDLE);
    end
  end

  // shift register and word counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= SSP_RX_IDLE;
      rx_shift_reg <= 8'h00;
      rx_cnt_reg   <= 3'd0;
    end else if (rx_fall) begin
      case (rx_state_reg)
        SSP_RX_IDLE: begin
          if (en & rx_fs) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sync2_reg[ssp_pkg::PIN_SRD]};
            rx_cnt_reg   <= 3'd1;
            rx_state_reg <= SSP_RX_SHIFT;
          end
        end
        SSP_RX_SHIFT: begin
          rx_shift_reg <= {rx_shift_reg[6:0], sync2_reg[ssp_pkg::PIN_SRD]};
          rx_cnt_reg   <= rx_cnt_reg + 3'd1;
          if (rx_cnt_reg == 3'd7) begin
            rx_state_reg <= SSP_RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= SSP_RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive holding register and flags
  // ----------------------------------------------------------------
  logic rx_pop;
  logic ovr_clr;
  assign rx_pop  = apb_done & ~pwrite & (paddr == ssp_pkg::OFF_RXD);
  assign ovr_clr = apb_done & pwrite & (paddr == ssp_pkg::OFF_STAT) & pwdata[ssp_pkg::ST_RX_OVR];

  // a word landing with a read or clear in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      rx_ovr_reg  <= 1'b0;
    end else begin
      if (rx_word_done) begin
        rx_data_reg <= {rx_shift_reg[6:0], sync2_reg[ssp_pkg::PIN_SRD]};
        rx_full_reg <= 1'b1;
        // an unread word being replaced is an overrun
        rx_ovr_reg  <= rx_ovr_reg | (rx_full_reg & ~rx_pop);
      end else begin
        rx_full_reg <= rx_full_reg & ~rx_pop;
        rx_ovr_reg  <= rx_ovr_reg & ~ovr_clr;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave: no wait state, more while the buffer is full
  // ----------------------------------------------------------------
  logic        mapped;
  logic        accept;
  logic        pready_next;
  logic [31:0] rd_mux;
  logic [31:0] status;
  assign status = {27'h0, tx_state_reg == SSP_TX_SHIFT, rx_ovr_reg, rx_full_reg,
                   ~txf_in_ready, ~txf_out_valid};
  assign mapped = (paddr[1:0] == 2'b00) & (paddr <= ssp_pkg::OFF_STAT);
  // a transmit write stalls until the buffer has room
  assign accept = ~(mapped & pwrite & (paddr == ssp_pkg::OFF_TXD)) | txf_in_ready;
  assign pready_next = psel & ~(penable & pready_reg) & accept;
  assign apb_done    = psel & penable & pready_reg;

  // read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ssp_pkg::OFF_CTRL: rd_mux = ctrl_reg;
      ssp_pkg::OFF_PCR:  rd_mux = {26'h0, pcr_reg};
      ssp_pkg::OFF_PDR:  rd_mux = {26'h0, pdr_reg};
      ssp_pkg::OFF_GPIO: rd_mux = {26'h0, sync2_reg};
      ssp_pkg::OFF_RXD:  rd_mux = {24'h0, rx_data_reg};
      ssp_pkg::OFF_STAT: rd_mux = status;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // response flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pready_next & ~mapped;
      prdata_reg  <= (pready_next & ~pwrite & mapped) ? rd_mux : 32'h0000_0000;
    end
  end

  // software-written registers; pins come up as gpio inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ssp_pkg::CTRL_RST;
      pcr_reg  <= ssp_pkg::PCR_RST;
      pdr_reg  <= ssp_pkg::PDR_RST;
      gpio_reg <= ssp_pkg::GPIO_RST;
    end else if (apb_done & pwrite) begin
      case (paddr)
        ssp_pkg::OFF_CTRL: ctrl_reg <= pwdata;
        ssp_pkg::OFF_PCR:  pcr_reg  <= pwdata[5:0];
        ssp_pkg::OFF_PDR:  pdr_reg  <= pwdata[5:0];
        ssp_pkg::OFF_GPIO: gpio_reg <= pwdata[5:0];
        default:           ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial roles of each pin
  // ----------------------------------------------------------------
  logic [5:0] ser_out;
  logic [5:0] ser_oe;
  logic       flags;
  assign flags = ctrl_reg[ssp_pkg::CTRL_FLAGS];

  // routing follows the operating mode
  always_comb begin
    ser_out = 6'h00;
    ser_oe  = 6'h00;
    if (sync_mode) begin
      // second and third transmitters copy the main stream
      ser_out[ssp_pkg::PIN_SC0] = flags ? ctrl_reg[ssp_pkg::CTRL_FLAG0] : tx_shift_reg[7];
      ser_out[ssp_pkg::PIN_SC1] = flags ? ctrl_reg[ssp_pkg::CTRL_FLAG1] : tx_shift_reg[7];
      ser_oe[ssp_pkg::PIN_SC0]  = 1'b1;
      ser_oe[ssp_pkg::PIN_SC1]  = 1'b1;
    end else begin
      ser_out[ssp_pkg::PIN_SC0] = int_clk_reg;
      ser_oe[ssp_pkg::PIN_SC0]  = rxck_out;
      ser_out[ssp_pkg::PIN_SC1] = rxfs_drive_reg;
      ser_oe[ssp_pkg::PIN_SC1]  = rxfs_out;
    end
    ser_out[ssp_pkg::PIN_SC2] = fs_drive_reg;
    ser_oe[ssp_pkg::PIN_SC2]  = fs_out;
    ser_out[ssp_pkg::PIN_SCK] = int_clk_reg;
    ser_oe[ssp_pkg::PIN_SCK]  = sck_out;
    ser_oe[ssp_pkg::PIN_SRD]  = 1'b0;
    ser_out[ssp_pkg::PIN_STD] = tx_shift_reg[7];
    ser_oe[ssp_pkg::PIN_STD]  = (tx_state_reg == SSP_TX_SHIFT);
  end

  // per-pin choice between serial function and gpio
  genvar gi;
  generate
    for (gi = 0; gi < ssp_pkg::NPIN; gi++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out_reg[gi] <= 1'b0;
          pin_oe_reg[gi]  <= 1'b0;
        end else begin
          pin_out_reg[gi] <= pcr_reg[gi] ? ser_out[gi] : gpio_reg[gi];
          pin_oe_reg[gi]  <= pcr_reg[gi] ? ser_oe[gi] : pdr_reg[gi];
        end
      end
    end
  endgenerate

  assign pin_out = pin_out_reg;
  assign pin_oe  = pin_oe_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata  = prdata_reg;
endmodule
`default_nettype wire

// *** tb/ssp_port_chk.sv ***
// assertion checker bound to the serial port pin block
`timescale 1ns/1ps
`default_nettype none
module ssp_port_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  pin_in,
  input wire logic [5:0]  pin_out,
  input wire logic [5:0]  pin_oe
);
  logic [31:0] ctrl_q;        // shadow of the mode register
  logic [5:0]  pcr_q, pdr_q;  // shadow of pin select and direction
  logic [1:0]  quiet;         // cycles since a write; pins settle after one
  wire  logic  wr = psel & penable & pready & pwrite;
  // track what software wrote, so pin roles can be predicted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      {ctrl_q, pcr_q, pdr_q, quiet} <= {ssp_pkg::CTRL_RST, 14'h0};
    else begin
      quiet <= wr ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      if (wr && paddr == ssp_pkg::OFF_CTRL) ctrl_q <= pwdata;
      if (wr && paddr == ssp_pkg::OFF_PCR) pcr_q <= pwdata[5:0];
      if (wr && paddr == ssp_pkg::OFF_PDR) pdr_q <= pwdata[5:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  chk_gpio_dir:
    assert property (quiet == 2'h3 |-> ((pin_oe ^ pdr_q) & ~pcr_q) == 6'h00) else $error("gpio direction");
  chk_rx_input:
    assert property (quiet == 2'h3 && pcr_q[4] |-> !pin_oe[4]) else $error("rx line driven");
  chk_clk_input:
    assert property (quiet == 2'h3 && pcr_q[3] && !ctrl_q[2] |-> !pin_oe[3]) else $error("clock driven");
  chk_fs_input:
    assert property (quiet == 2'h3 && pcr_q[2] && !ctrl_q[3] |-> !pin_oe[2]) else $error("sync driven");
  chk_async_roles:
    assert property (quiet == 2'h3 && pcr_q[0] && ctrl_q[2:1] == 2'h0 && !ctrl_q[4] |-> !pin_oe[0]) else $error("line zero");
  cover property (wr && paddr == ssp_pkg::OFF_TXD);
  cover property (pslverr);
  cover property (pin_oe[5]);
endmodule
bind ssp_port ssp_port_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .pin_in, .pin_out, .pin_oe);
`default_nettype wire

// *** tb/ssp_far_end.sv ***
// far-end codec model: external bit clock, frame sync and receive data
`timescale 1ns/1ps
`default_nettype none
module ssp_far_end (
  output logic      sck,
  output logic      fs,
  output logic      rxd,
  input  wire logic txd
);
  initial begin
    {sck, fs, rxd} = 3'h0; // clock stands still between frames
  end
  // one word msb first; data moves mid low half, away from both edges
  task automatic frame(input logic [7:0] w, output logic [7:0] got);
    #7;
    for (int i = 0; i <= 8; i++) begin
      #50;
      if (i > 0) got = {got[6:0], txd};
      if (i < 8) begin
        fs = (i == 0);
        rxd = w[7-i];
        #50 sck = 1'b1;
        #100 sck = 1'b0;
      end
    end
    fs = 1'b0;
    rxd = ~rxd; // released line must not look like a held bit
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// testbench for the serial port pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; $display("unexpected at %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sck, fs, rxd;
  logic [7:0]  paddr, w;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  pin_in, pin_out, pin_oe, ext;
  logic [31:0] cv [4] = '{32'h0003_00c3, 32'h0003_0143, 32'h0003_0031, 32'h0003_0001};
  logic [3:0]  ev [4] = '{4'hd, 4'he, 4'hc, 4'h0};
  int          mismatches, n_compared;
  // driven pins read back their own level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {ext[5], rxd, sck, fs, ext[1:0]});
  ssp_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_in, .pin_out, .pin_oe);
  ssp_far_end far (.sck, .fs, .rxd, .txd(pin_in[5]));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("mismatches %0d n_compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one apb transfer; waits for pready under a bound
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    {er, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    ext = 6'h01;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(pin_oe, 6'h00)
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      `CHK(rd, i ? 32'h0 : ssp_pkg::CTRL_RST)
    end
    xfer(1'b1, ssp_pkg::OFF_PDR, 32'h2a);
    xfer(1'b1, ssp_pkg::OFF_GPIO, 32'h3f);
    repeat (4) @(posedge pclk);
    xfer(1'b0, ssp_pkg::OFF_GPIO, 32'h0);
    `CHK(rd, 32'h2b)
    xfer(1'b0, 8'h1c, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    xfer(1'b1, ssp_pkg::OFF_PDR, 32'h0);
    xfer(1'b1, ssp_pkg::OFF_PCR, 32'h3f);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ssp_pkg::OFF_CTRL, cv[i]);
      repeat (4) @(posedge pclk);
      `CHK({pin_oe[1:0], pin_out[1:0] & {2{i < 2}}}, ev[i])
    end
    xfer(1'b1, ssp_pkg::OFF_PCR, 32'h3c);
    xfer(1'b1, ssp_pkg::OFF_CTRL, 32'h0003_0002);
    xfer(1'b1, ssp_pkg::OFF_PDR, 32'h01);
    for (int i = 0; i < 8; i++) xfer(1'b1, ssp_pkg::OFF_TXD, 32'h5a + i);
    xfer(1'b0, ssp_pkg::OFF_STAT, 32'h0);
    `CHK({pin_oe[1:0], rd[1:0]}, 4'h6)
    xfer(1'b1, ssp_pkg::OFF_CTRL, 32'h0003_0003);
    for (int i = 0; i < 8; i++) begin
      far.frame(8'hc3 ^ 8'(i), w);
      `CHK(w, 8'h5a + 8'(i))
      repeat (4) @(posedge pclk);
      xfer(1'b0, ssp_pkg::OFF_RXD, 32'h0);
      `CHK(rd, {24'h0, 8'hc3 ^ 8'(i)})
    end
    xfer(1'b0, ssp_pkg::OFF_STAT, 32'h0);
    `CHK(rd[0], 1'b1)
    // empty buffer leaves the line undriven; two unread words overrun
    for (int i = 0; i < 2; i++) begin
      far.frame(8'h96 + 8'(i), w);
      `CHK(w, 8'h00)
    end
    repeat (4) @(posedge pclk);
    xfer(1'b0, ssp_pkg::OFF_STAT, 32'h0);
    `CHK(rd, 32'h0000_000d)
    xfer(1'b1, ssp_pkg::OFF_STAT, 32'h08);
    xfer(1'b0, ssp_pkg::OFF_RXD, 32'h0);
    `CHK(rd, 32'h0000_0097)
    xfer(1'b0, ssp_pkg::OFF_STAT, 32'h0);
    `CHK(rd, 32'h0000_0001)
    // port drives its own bit clock and frame sync
    xfer(1'b1, ssp_pkg::OFF_CTRL, 32'h0003_000f);
    repeat (4) @(posedge pclk);
    `CHK(pin_oe[3:2], 2'h3)
    complete_run();
  end
endmodule
`default_nettype wire
